// [rtl/tsal_top.sv]
// Purpose: thermal status flags, alarm outputs, diode fault sequencing
// Assumes: limits, masks, temperature compare results come from outside
// Notes: the serial engine presents byte reads and writes on a strobe port
// Functional notes
// - Primary high flag per channel set when temperature above its limit.
// - Primary low flag per channel set when below shared low limit.
// - Secondary high flag per channel set when above secondary limit.
// - Secondary low flag per channel set when below secondary low limit.
// - Status flags clear on read, set again after next conversion.
// - Comparator mode alarms ignore reads, follow current compare and mask.
// - Interrupt mode alarms follow unmasked status flags.
// - Interrupt alarm clears on status read or alert response, may reassert.
// - Diode fault sets channel fault flag and forces result to zero.
// - Faulted channel raises no alarm and no limit event.
// - First 3 ms of each channel slot is diode fault detection.
// - Detected diode fault abandons channel, moves to next channel.
// - Diode fault flags clear on read, set again while fault persists.
// - Fault register uses bits 4..1; bits 0 and 7..5 reserved.
// - Stop bit finishes current sequence then standby; zero converts always.
// - Standby halts converter, serial interface stays working.
// - Soft reset bit restores power-on values then clears itself.
// - With timeout enabled, stalled serial clock 35 ms resets interface.
// - Control bit 4 picks primary alarm mode: 0 interrupt, 1 comparator, resets 1; secondary mode comes from sec_mode_sel.
// - Bits 3..2 set consecutive primary faults needed for alarm and flags.
// - Queue code 00 one, 01 two, 10 four, 11 six.
// - Control bit 1 selects extended temperature range format.
// - One-shot bit converts all enabled channels, only while stopped.
// - One-shot bit clears itself when the single cycle completes.
`timescale 1ns/1ps
module tsal_top
	import tsal_pkg::*;
#(
	parameter int NUM_CH = 5,
	parameter int CHECK_CYCLES = FAULT_CHECK_CYCLES,
	parameter int MEASURE_CYCLES = 1000,
	parameter int TIMEOUT_LIMIT = TIMEOUT_CYCLES
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register access from the serial engine
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic alert_resp_ack,
	// Serial clock activity for the timeout
	input wire logic bus_start,
	input wire logic bus_clk_edge,
	output logic bus_timeout_reset,
	// Analogue front end results
	input wire logic [NUM_CH-1:0] chan_enable,
	input wire logic diode_fault_det,
	input wire logic [15:0] adc_result,
	input wire logic over_pri_limit,
	input wire logic under_pri_limit,
	input wire logic over_sec_limit,
	input wire logic under_sec_limit,
	input wire logic [NUM_CH-1:0] sec_cmp_fault,
	input wire logic [NUM_CH-1:0] pri_mask,
	input wire logic [NUM_CH-1:0] sec_mask,
	input wire logic sec_mode_sel,
	// Converter control and results
	output logic adc_active,
	output logic [2:0] adc_channel,
	output logic adc_measuring,
	output logic result_valid,
	output logic [15:0] result_data,
	output logic extended_range,
	// Alarm pins, open drain
	output logic primary_alarm_n,
	output logic primary_alarm_oe,
	output logic secondary_alarm_n,
	output logic secondary_alarm_oe
);
	typedef enum logic [1:0] {TSAL_IDLE, TSAL_CHECK, TSAL_MEASURE} tsal_state_t;
	tsal_state_t state_reg, state_next;
	logic [7:0] ctl_reg, ctl_next;
	logic [NUM_CH-1:0] ph_reg, pl_reg, sh_reg, sl_reg;
	logic [NUM_CH-1:0] ph_next, pl_next, sh_next, sl_next;
	logic [NUM_CH-1:0] fault_reg, fault_next;
	logic [NUM_CH-1:0] chfault_reg, chfault_next;
	logic [NUM_CH-1:0] cmp_pri_reg, cmp_pri_next;
	logic [2:0] queue_reg [NUM_CH];
	logic [2:0] ch_reg, ch_next;
	logic [31:0] cnt_reg, cnt_next;
	logic [31:0] tout_reg, tout_next;
	logic tout_arm_reg, tout_arm_next;
	logic int_pri_reg, int_pri_next, int_sec_reg, int_sec_next;
	logic oneshot_run_reg;
	logic valid_reg;
	logic [15:0] data_reg;
	// Register decode
	wire rd_ph = reg_rd && reg_addr == ADDR_PRI_HIGH;
	wire rd_pl = reg_rd && reg_addr == ADDR_PRI_LOW;
	wire rd_sh = reg_rd && reg_addr == ADDR_SEC_HIGH;
	wire rd_sl = reg_rd && reg_addr == ADDR_SEC_LOW;
	wire rd_fault = reg_rd && reg_addr == ADDR_SENSOR_FAULT;
	wire wr_ctl = reg_wr && reg_addr == ADDR_CONTROL_ONE;
	wire stop_bit = ctl_reg[CTL_STOP_BIT];
	wire oneshot_bit = ctl_reg[CTL_ONE_SHOT_BIT];
	wire comp_mode = ctl_reg[CTL_MODE_BIT];
	wire [1:0] queue_code = ctl_reg[CTL_QUEUE_HI_BIT:CTL_QUEUE_LO_BIT];
	wire soft_reset = ctl_reg[CTL_SOFT_RESET_BIT];
	wire rst_all = rst || soft_reset;
	wire [2:0] queue_depth = queue_code == 2'h0 ? QUEUE_DEPTH_0 :
		queue_code == 2'h1 ? QUEUE_DEPTH_1 :
		queue_code == 2'h2 ? QUEUE_DEPTH_2 : QUEUE_DEPTH_3;
	// Sequencer events
	wire last_ch = ch_reg == 3'(NUM_CH - 1);
	wire check_done = state_reg == TSAL_CHECK &&
		cnt_reg == 32'(CHECK_CYCLES - 1);
	wire meas_done = state_reg == TSAL_MEASURE &&
		cnt_reg == 32'(MEASURE_CYCLES - 1);
	// fault abandons the slot at once
	wire abandon = state_reg == TSAL_CHECK && diode_fault_det && ch_reg != 3'h0;
	wire slot_end = meas_done || abandon || (state_reg != TSAL_IDLE &&
		!chan_enable[ch_reg]);
	wire seq_end = slot_end && last_ch;
	// start when running, or one-shot while stopped
	wire may_start = !stop_bit || oneshot_bit;
	wire [NUM_CH-1:0] ch_hot = NUM_CH'(1) << ch_reg;
	wire pri_fault_now = over_pri_limit || under_pri_limit;
	wire [2:0] q_now = queue_reg[ch_reg];
	wire q_met = pri_fault_now && (q_now + 3'h1 >= queue_depth);
	// Conversion sequencer, channel slots in order
	always_comb
	begin
		state_next = state_reg;
		ch_next = ch_reg;
		cnt_next = cnt_reg + 32'h1;
		case (state_reg)
			TSAL_IDLE:
			begin
				cnt_next = 32'h0;
				ch_next = 3'h0;
				if (may_start)
					state_next = TSAL_CHECK;
			end
			TSAL_CHECK:
			begin
				if (check_done)
				begin
					state_next = TSAL_MEASURE;
					cnt_next = 32'h0;
				end
			end
			default:
				cnt_next = cnt_reg + 32'h1;
		endcase
		if (slot_end)
		begin
			cnt_next = 32'h0;
			ch_next = last_ch ? 3'h0 : ch_reg + 3'h1;
			state_next = (last_ch && (stop_bit || oneshot_run_reg)) ?
				TSAL_IDLE : TSAL_CHECK;
		end
	end
	// Control register next value
	always_comb
	begin
		ctl_next = ctl_reg;
		if (wr_ctl)
			ctl_next = reg_wdata;
		// one-shot ends when its sequence completes
		if (seq_end && oneshot_run_reg)
			ctl_next[CTL_ONE_SHOT_BIT] = 1'b0;
		if (!ctl_next[CTL_STOP_BIT])
			ctl_next[CTL_ONE_SHOT_BIT] = 1'b0;
	end
	// Flag updates; set beats a same-cycle read clear
	always_comb
	begin
		ph_next = ph_reg;
		pl_next = pl_reg;
		sh_next = sh_reg;
		sl_next = sl_reg;
		fault_next = fault_reg;
		chfault_next = chfault_reg;
		cmp_pri_next = cmp_pri_reg;
		if (rd_ph)
			ph_next = '0;
		if (rd_pl)
			pl_next = '0;
		if (rd_sh)
			sh_next = '0;
		if (rd_sl)
			sl_next = '0;
		if (rd_fault)
			fault_next = '0;
		if (abandon)
		begin
			fault_next = fault_next | ch_hot;
			chfault_next = chfault_reg | ch_hot;
		end
		// only healthy completed slots raise events
		if (meas_done)
		begin
			chfault_next = chfault_reg & ~ch_hot;
			// primary flags after the queue fills
			if (q_met && over_pri_limit)
				ph_next = ph_next | ch_hot;
			if (q_met && under_pri_limit)
				pl_next = pl_next | ch_hot;
			cmp_pri_next = q_met ? (cmp_pri_reg | ch_hot) :
				(pri_fault_now ? cmp_pri_reg : cmp_pri_reg & ~ch_hot);
			if (over_sec_limit)
				sh_next = sh_next | ch_hot;
			if (under_sec_limit)
				sl_next = sl_next | ch_hot;
		end
		if (abandon)
			cmp_pri_next = cmp_pri_reg & ~ch_hot;
		// keep the reserved fault bit clear
		fault_next[0] = 1'b0;
	end
	// interrupt latches, cleared by read or alert response
	// Every unmasked flag set raises it, so a lasting fault reasserts
	wire pri_any = meas_done && q_met && |(ch_hot & ~pri_mask);
	wire sec_any = meas_done && (over_sec_limit || under_sec_limit) &&
		|(ch_hot & ~sec_mask);
	wire pri_clr = rd_ph || rd_pl || alert_resp_ack;
	wire sec_clr = rd_sh || rd_sl || alert_resp_ack;
	assign int_pri_next = pri_any ? 1'b1 : (pri_clr ? 1'b0 : int_pri_reg);
	assign int_sec_next = sec_any ? 1'b1 : (sec_clr ? 1'b0 : int_sec_reg);
	always_comb
	begin
		tout_arm_next = tout_arm_reg;
		tout_next = tout_arm_reg ? tout_reg + 32'h1 : 32'h0;
		if (bus_start)
			tout_arm_next = 1'b1;
		if (bus_start || bus_clk_edge)
			tout_next = 32'h0;
		if (!ctl_reg[CTL_TIMEOUT_BIT] || bus_timeout_reset)
		begin
			tout_arm_next = 1'b0;
			tout_next = 32'h0;
		end
	end
	assign bus_timeout_reset = tout_arm_reg &&
		tout_reg >= 32'(TIMEOUT_LIMIT - 1);
	// comparator alarms from live compare state and masks
	wire [NUM_CH-1:0] sec_live = sec_cmp_fault & ~chfault_reg;
	wire pri_comp = |(cmp_pri_reg & ~chfault_reg & ~pri_mask);
	wire sec_comp = |(sec_live & ~sec_mask);
	wire pri_on = comp_mode ? pri_comp : int_pri_reg;
	wire sec_on = sec_mode_sel ? sec_comp : int_sec_reg;
	assign primary_alarm_n = 1'b0;
	assign secondary_alarm_n = 1'b0;
	assign primary_alarm_oe = pri_on;
	assign secondary_alarm_oe = sec_on;
	// Register read mux; reserved bits read as zero
	assign reg_rdata = reg_addr == ADDR_PRI_HIGH ? 8'(ph_reg) :
		reg_addr == ADDR_PRI_LOW ? 8'(pl_reg) :
		reg_addr == ADDR_SEC_HIGH ? 8'(sh_reg) :
		reg_addr == ADDR_SEC_LOW ? 8'(sl_reg) :
		reg_addr == ADDR_SENSOR_FAULT ? 8'(fault_reg) :
		reg_addr == ADDR_CONTROL_ONE ? ctl_reg : 8'h00;
	assign adc_active = state_reg != TSAL_IDLE;
	assign adc_channel = ch_reg;
	assign adc_measuring = state_reg == TSAL_MEASURE;
	assign result_valid = valid_reg;
	assign result_data = data_reg;
	// range selection drives the data formatter
	assign extended_range = ctl_reg[CTL_EXT_RANGE_BIT];
	// soft reset restores everything but the timeout, the bit clears with it
	always_ff @(posedge core_clk)
	begin
		if (rst_all)
		begin
			state_reg <= TSAL_IDLE;
			ctl_reg <= CTL_RESET_VALUE;
			ph_reg <= '0;
			pl_reg <= '0;
			sh_reg <= '0;
			sl_reg <= '0;
			fault_reg <= '0;
			chfault_reg <= '0;
			cmp_pri_reg <= '0;
			ch_reg <= 3'h0;
			cnt_reg <= 32'h0;
			int_pri_reg <= 1'b0;
			int_sec_reg <= 1'b0;
			oneshot_run_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			ctl_reg <= ctl_next;
			ph_reg <= ph_next;
			pl_reg <= pl_next;
			sh_reg <= sh_next;
			sl_reg <= sl_next;
			fault_reg <= fault_next;
			chfault_reg <= chfault_next;
			cmp_pri_reg <= cmp_pri_next;
			ch_reg <= ch_next;
			cnt_reg <= cnt_next;
			int_pri_reg <= int_pri_next;
			int_sec_reg <= int_sec_next;
			if (state_reg == TSAL_IDLE)
				oneshot_run_reg <= may_start && stop_bit;
		end
	end
	// Timeout runs on hardware reset only, serial side keeps working
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			tout_reg <= 32'h0;
			tout_arm_reg <= 1'b0;
		end
		else
		begin
			tout_reg <= tout_next;
			tout_arm_reg <= tout_arm_next;
		end
	end
	// result register, zero on diode fault
	always_ff @(posedge core_clk)
	begin
		if (rst_all)
		begin
			valid_reg <= 1'b0;
			data_reg <= FAULT_TEMP_VALUE;
		end
		else
		begin
			valid_reg <= meas_done || abandon;
			if (abandon)
				data_reg <= FAULT_TEMP_VALUE;
			else if (meas_done)
				data_reg <= adc_result;
		end
	end
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++)
		begin : g_queue
			always_ff @(posedge core_clk)
			begin
				if (rst_all || (abandon && ch_reg == 3'(gi)))
					queue_reg[gi] <= 3'h0;
				else if (meas_done && ch_reg == 3'(gi))
					queue_reg[gi] <= !pri_fault_now ? 3'h0 :
						(q_met ? q_now : q_now + 3'h1);
			end
		end
	endgenerate
	// Assertions
	// faulted slot stores zero
	a_fault_zero: assert property (@(posedge core_clk) disable iff (rst_all)
		abandon |=> data_reg == FAULT_TEMP_VALUE && valid_reg)
		else $error("fault result not zero");
	a_fault_rsvd: assert property (@(posedge core_clk) disable iff (rst)
		fault_reg[0] == 1'b0)
		else $error("reserved fault bit set");
	// read clears a flag when no new set
	a_read_clear: assert property (@(posedge core_clk) disable iff (rst_all)
		rd_ph && !meas_done |=> ph_reg == '0)
		else $error("status not cleared by read");
	a_oneshot_stop: assert property (@(posedge core_clk) disable iff (rst)
		oneshot_bit |-> stop_bit)
		else $error("one-shot without stop");
	a_int_ack: assert property (@(posedge core_clk) disable iff (rst_all)
		alert_resp_ack && !pri_any && !comp_mode |=> !primary_alarm_oe)
		else $error("alarm not cleared by alert response");
	// abandon moves to the next channel
	a_abandon_next: assert property (@(posedge core_clk) disable iff (rst_all)
		abandon && !last_ch |=> ch_reg == $past(ch_reg) + 3'h1)
		else $error("abandon did not advance");
	// stopped sequencer idles after the last slot
	a_stop_idle: assert property (@(posedge core_clk) disable iff (rst_all)
		seq_end && stop_bit && !wr_ctl |=> state_reg == TSAL_IDLE)
		else $error("no standby after sequence");
	a_tout_pulse: assert property (@(posedge core_clk) disable iff (rst)
		bus_timeout_reset |=> !bus_timeout_reset)
		else $error("timeout held");
endmodule

// [include/tsal_pkg.sv]
// Purpose: shared constants for the thermal status and alarm logic
// Assumes: 10 MHz core clock, five channels (local plus four remote)
// Notes: register offsets are byte addresses of the serial register space
package tsal_pkg;
	localparam int CORE_CLK_HZ = 10_000_000;
	// Register offsets
	localparam logic [7:0] ADDR_PRI_HIGH = 8'h0c;
	localparam logic [7:0] ADDR_PRI_LOW = 8'h0d;
	localparam logic [7:0] ADDR_CONTROL_ONE = 8'h0f;
	localparam logic [7:0] ADDR_SEC_HIGH = 8'h42;
	localparam logic [7:0] ADDR_SEC_LOW = 8'h43;
	localparam logic [7:0] ADDR_SENSOR_FAULT = 8'h44;
	// Control register fields
	localparam int CTL_STOP_BIT = 7;
	localparam int CTL_SOFT_RESET_BIT = 6;
	localparam int CTL_TIMEOUT_BIT = 5;
	localparam int CTL_MODE_BIT = 4;
	localparam int CTL_QUEUE_HI_BIT = 3;
	localparam int CTL_QUEUE_LO_BIT = 2;
	localparam int CTL_EXT_RANGE_BIT = 1;
	localparam int CTL_ONE_SHOT_BIT = 0;
	localparam logic [7:0] CTL_RESET_VALUE = 8'h10;
	localparam logic [7:0] FLAGS_RESET_VALUE = 8'h00;
	// Fault queue depths for codes 00, 01, 10, 11
	localparam logic [2:0] QUEUE_DEPTH_0 = 3'h1;
	localparam logic [2:0] QUEUE_DEPTH_1 = 3'h2;
	localparam logic [2:0] QUEUE_DEPTH_2 = 3'h4;
	localparam logic [2:0] QUEUE_DEPTH_3 = 3'h6;
	// Diode fault check window and serial clock timeout
	localparam int FAULT_CHECK_MS = 3;
	localparam int TIMEOUT_MS = 35;
	localparam int FAULT_CHECK_CYCLES = FAULT_CHECK_MS * (CORE_CLK_HZ / 1000);
	localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CORE_CLK_HZ / 1000);
	localparam logic [15:0] FAULT_TEMP_VALUE = 16'h0000;
endpackage

// [testbench/tsal_host_model.sv]
// Purpose: host side model issuing register reads, writes, alert response
// Assumes: one-cycle strobes taken at the rising edge
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module tsal_host_model
	import tsal_pkg::*;
(
	// Clock
	input wire logic core_clk,
	// Register access
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Alert response
	output logic alert_resp_ack
);
	// Idle bus at time zero
	initial
	begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		alert_resp_ack = 1'b0;
	end

	// Byte write, held until the taking edge
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		if (a == ADDR_CONTROL_ONE && d[CTL_SOFT_RESET_BIT])
			repeat (2) @(posedge core_clk);
	endtask

	// Byte read, data taken at the same edge as the request
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		d = reg_rdata;
		reg_rd <= 1'b0;
		reg_addr <= ~a;
	endtask

	task automatic alert_response();
		@(posedge core_clk);
		alert_resp_ack <= 1'b1;
		@(posedge core_clk);
		alert_resp_ack <= 1'b0;
	endtask
endmodule

// [testbench/thermal_status_alarm_logic_tb.sv]
// Purpose: self-checking bench for status flags, alarms and control bits
// Assumes: short check, measure and timeout counts of 4, 4 and 10
// Notes: conversions are run one shot at a time to keep flags predictable
`timescale 1ns/1ps
module thermal_status_alarm_logic_tb;
	import tsal_pkg::*;
	logic core_clk, rst, bus_start, bus_clk_edge, diode_fault_det;
	logic over_pri_limit, under_pri_limit, over_sec_limit, under_sec_limit;
	logic sec_mode_sel, reg_wr, reg_rd, alert_resp_ack, bus_timeout_reset;
	logic adc_active, adc_measuring, result_valid, extended_range;
	logic primary_alarm_oe, secondary_alarm_oe;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, ctl_base;
	logic [4:0] chan_enable, sec_cmp_fault, pri_mask, sec_mask;
	logic [15:0] adc_result, result_data;
	logic [2:0] adc_channel;
	int err_total, comparisons, zero_cnt, good_cnt, meas_cnt, wd_cnt;

	tsal_top #(.CHECK_CYCLES(4), .MEASURE_CYCLES(4), .TIMEOUT_LIMIT(10))
		tsal_top_inst (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .alert_resp_ack(alert_resp_ack),
		.bus_start(bus_start), .bus_clk_edge(bus_clk_edge),
		.bus_timeout_reset(bus_timeout_reset), .chan_enable(chan_enable),
		.diode_fault_det(diode_fault_det), .adc_result(adc_result),
		.over_pri_limit(over_pri_limit), .under_pri_limit(under_pri_limit),
		.over_sec_limit(over_sec_limit), .under_sec_limit(under_sec_limit),
		.sec_cmp_fault(sec_cmp_fault), .pri_mask(pri_mask),
		.sec_mask(sec_mask), .sec_mode_sel(sec_mode_sel),
		.adc_active(adc_active), .adc_channel(adc_channel),
		.adc_measuring(adc_measuring), .result_valid(result_valid),
		.result_data(result_data), .extended_range(extended_range),
		.primary_alarm_n(), .primary_alarm_oe(primary_alarm_oe),
		.secondary_alarm_n(), .secondary_alarm_oe(secondary_alarm_oe));
	tsal_host_model tsal_host_model_inst (.core_clk(core_clk),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.alert_resp_ack(alert_resp_ack));

	// 10 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// Event counters, read as before and after differences
	always @(posedge core_clk)
	begin
		if (result_valid === 1'b1 && result_data === 16'h0000) zero_cnt++;
		if (result_valid === 1'b1 && result_data !== 16'h0000) good_cnt++;
		if (adc_measuring === 1'b1) meas_cnt++;
		if (bus_timeout_reset === 1'b1) wd_cnt++;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] expd);
		comparisons++;
		if (seen !== expd)
		begin
			err_total++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, expd);
		end
	endtask
	task automatic chk1(input logic seen, input logic expd);
		check({7'h00, seen}, {7'h00, expd});
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		tsal_host_model_inst.read_reg(a, v);
		check(v, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		tsal_host_model_inst.write_reg(a, d);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (adc_active !== 1'b0 && n < 200)
		begin
			@(posedge core_clk);
			n++;
		end
		chk1(adc_active, 1'b0);
		check({5'h00, adc_channel}, 8'h00);
	endtask
	// One conversion pass from standby; bit 0 must drop by itself
	task automatic one_shot();
		logic [7:0] v;
		int n;
		wr(ADDR_CONTROL_ONE, ctl_base | 8'h01);
		n = 0;
		v = 8'h01;
		while (v[0] !== 1'b0 && n < 100)
		begin
			tsal_host_model_inst.read_reg(ADDR_CONTROL_ONE, v);
			n++;
		end
		check(v, ctl_base);
		wait_idle();
	endtask
	task automatic set_in(input logic ovp, unp, ovs, uns);
		@(posedge core_clk);
		over_pri_limit <= ovp;
		under_pri_limit <= unp;
		over_sec_limit <= ovs;
		under_sec_limit <= uns;
	endtask

	// Power-on values and unmapped space
	task automatic t_reset_values();
		rd_chk(ADDR_CONTROL_ONE, CTL_RESET_VALUE);
		rd_chk(ADDR_PRI_HIGH, FLAGS_RESET_VALUE);
		rd_chk(ADDR_SEC_LOW, FLAGS_RESET_VALUE);
		rd_chk(ADDR_SENSOR_FAULT, FLAGS_RESET_VALUE);
		rd_chk(8'h55, 8'h00);
		chk1(adc_active, 1'b1);
		chk1(extended_range, 1'b0);
	endtask

	// Limit flags, clear on read, comparator alarm and masks
	task automatic t_flags();
		ctl_base = 8'h90;
		wr(ADDR_CONTROL_ONE, ctl_base);
		wait_idle();
		set_in(1'b1, 1'b0, 1'b1, 1'b0);
		one_shot();
		rd_chk(ADDR_PRI_HIGH, 8'h1f);
		rd_chk(ADDR_PRI_HIGH, 8'h00);
		chk1(secondary_alarm_oe, 1'b1);
		rd_chk(ADDR_SEC_HIGH, 8'h1f);
		@(negedge core_clk);
		chk1(secondary_alarm_oe, 1'b0);
		rd_chk(ADDR_PRI_LOW, 8'h00);
		chk1(primary_alarm_oe, 1'b1);
		set_in(1'b0, 1'b1, 1'b0, 1'b1);
		one_shot();
		rd_chk(ADDR_PRI_LOW, 8'h1f);
		rd_chk(ADDR_SEC_LOW, 8'h1f);
		rd_chk(ADDR_PRI_HIGH, 8'h00);
		set_in(1'b0, 1'b0, 1'b0, 1'b0);
		one_shot();
		chk1(primary_alarm_oe, 1'b0);
		set_in(1'b1, 1'b0, 1'b0, 1'b0);
		one_shot();
		chk1(primary_alarm_oe, 1'b1);
		pri_mask <= 5'h1f;
		sec_mode_sel <= 1'b1;
		sec_cmp_fault <= 5'h04;
		repeat (3) @(posedge core_clk);
		chk1(primary_alarm_oe, 1'b0);
		chk1(secondary_alarm_oe, 1'b1);
		sec_mask <= 5'h04;
		pri_mask <= 5'h00;
		repeat (3) @(posedge core_clk);
		chk1(secondary_alarm_oe, 1'b0);
	endtask

	// Interrupt alarm: set, read clear, alert clear, mask
	task automatic t_alarm_int();
		ctl_base = 8'h80;
		wr(ADDR_CONTROL_ONE, ctl_base);
		one_shot();
		chk1(primary_alarm_oe, 1'b1);
		rd_chk(ADDR_PRI_HIGH, 8'h1f);
		@(negedge core_clk);
		chk1(primary_alarm_oe, 1'b0);
		one_shot();
		chk1(primary_alarm_oe, 1'b1);
		tsal_host_model_inst.alert_response();
		@(negedge core_clk);
		chk1(primary_alarm_oe, 1'b0);
		one_shot();
		chk1(primary_alarm_oe, 1'b1);
		rd_chk(ADDR_PRI_HIGH, 8'h1f);
		pri_mask <= 5'h1f;
		one_shot();
		chk1(primary_alarm_oe, 1'b0);
		pri_mask <= 5'h01;
	endtask

	// Remote diode faults abandon the slot and give a zero result
	task automatic t_diode();
		int z, g, m;
		rd_chk(ADDR_PRI_HIGH, 8'h1f);
		diode_fault_det <= 1'b1;
		z = zero_cnt;
		g = good_cnt;
		m = meas_cnt;
		one_shot();
		rd_chk(ADDR_SENSOR_FAULT, 8'h1e);
		rd_chk(ADDR_PRI_HIGH, 8'h01);
		chk1(primary_alarm_oe, 1'b0);
		check(8'(zero_cnt - z), 8'h04);
		check(8'(good_cnt - g), 8'h01);
		check(8'(meas_cnt - m), 8'h04);
		rd_chk(ADDR_SENSOR_FAULT, 8'h00);
		wr(ADDR_SENSOR_FAULT, 8'hff);
		rd_chk(ADDR_SENSOR_FAULT, 8'h00);
		diode_fault_det <= 1'b0;
		pri_mask <= 5'h00;
	endtask

	// Queue codes need 1, 2, 4 and 6 faults in a row
	task automatic t_queue();
		logic [7:0] v;
		int depth[4] = '{1, 2, 4, 6};
		for (int q = 0; q < 4; q++)
		begin
			ctl_base = 8'h80 | 8'(q << 2);
			set_in(1'b0, 1'b0, 1'b0, 1'b0);
			one_shot();
			tsal_host_model_inst.read_reg(ADDR_PRI_HIGH, v);
			set_in(1'b1, 1'b0, 1'b0, 1'b0);
			for (int i = 1; i < depth[q]; i++)
			begin
				one_shot();
				rd_chk(ADDR_PRI_HIGH, 8'h00);
			end
			one_shot();
			rd_chk(ADDR_PRI_HIGH, 8'h1f);
		end
	endtask

	// Extended range bit, then soft reset restores power-on values
	task automatic t_soft();
		set_in(1'b0, 1'b0, 1'b0, 1'b0);
		one_shot();
		wr(ADDR_CONTROL_ONE, 8'h82);
		@(negedge core_clk);
		chk1(extended_range, 1'b1);
		wr(ADDR_CONTROL_ONE, 8'h40);
		rd_chk(ADDR_CONTROL_ONE, CTL_RESET_VALUE);
		rd_chk(ADDR_PRI_HIGH, 8'h00);
		chk1(extended_range, 1'b0);
	endtask

	// Stalled serial clock after a start trips the interface reset
	task automatic t_watchdog();
		int w;
		wr(ADDR_CONTROL_ONE, 8'h30);
		w = wd_cnt;
		bus_start <= 1'b1;
		@(posedge core_clk);
		bus_start <= 1'b0;
		repeat (20) @(posedge core_clk);
		check(8'(wd_cnt - w), 8'h01);
		w = wd_cnt;
		bus_start <= 1'b1;
		for (int i = 0; i < 40; i++)
		begin
			@(posedge core_clk);
			bus_start <= 1'b0;
			bus_clk_edge <= (i % 5 == 0);
		end
		check(8'(wd_cnt - w), 8'h00);
	endtask

	task automatic complete_run();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Hang guard, far beyond the expected run of under two thousand cycles
	initial
	begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		complete_run();
	end

	// Main sequence
	initial
	begin
		{rst, bus_start, bus_clk_edge, diode_fault_det} = 4'h8;
		{over_pri_limit, under_pri_limit} = 2'h0;
		{over_sec_limit, under_sec_limit, sec_mode_sel} = 3'h0;
		{sec_cmp_fault, pri_mask, sec_mask} = 15'h0000;
		chan_enable = 5'h1f;
		adc_result = 16'h1234;
		ctl_base = CTL_RESET_VALUE;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		repeat (12) @(posedge core_clk);
		t_reset_values();
		t_flags();
		t_alarm_int();
		t_diode();
		t_queue();
		t_soft();
		t_watchdog();
		complete_run();
	end
endmodule
